//--- dv/eepc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl_sva
    import eepc_pkg::*;
#(
    parameter int ATOMIC_CYCLES = 340000,
    parameter int SPLIT_CYCLES  = 180000
) (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       por_in,
    input wire logic       ctl_wr_in,
    input wire logic       addr_wr_in,
    input wire logic       data_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       global_irq_en_in,
    input wire logic [7:0] ctl_rd_out,
    input wire logic [7:0] addr_rd_out,
    input wire logic [7:0] data_rd_out,
    input wire logic       ready_irq_out,
    input wire logic       cpu_stall_out
);
    // The length counter clears on power-on only, as the engine runs on through system reset.
    logic [19:0]      busy_cnt_ff;
    logic [19:0]      nxt_busy_cnt;
    wire logic        busy = ctl_rd_out[BIT_PROG_TRIG];
    wire logic        arm  = ctl_rd_out[BIT_MASTER_EN];
    wire logic [1:0]  mode = ctl_rd_out[BIT_MODE_HI:BIT_MODE_LO];
    wire logic [19:0] want = (mode == 2'h0) ? 20'(ATOMIC_CYCLES) : 20'(SPLIT_CYCLES);
    assign nxt_busy_cnt = busy ? busy_cnt_ff + 20'h1 : 20'h0;
    always_ff @(posedge clk_in or posedge por_in) begin
        if (por_in) begin
            busy_cnt_ff <= 20'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in || por_in);
    sequence trig_stall_s; cpu_stall_out [*2] ##1 !cpu_stall_out; endsequence
    sequence read_stall_s; cpu_stall_out [*4] ##1 !cpu_stall_out; endsequence
    irq_level_a: assert property (ready_irq_out == (ctl_rd_out[3] && global_irq_en_in && !busy))
        else $error("ready interrupt level wrong");
    arm_hold_a: assert property ($rose(arm) |-> arm [*4])
        else $error("master enable dropped early");
    trig_gate_a: assert property (ctl_wr_in && wdata_in[1] && !arm && !busy |=> !busy)
        else $error("trigger accepted without master enable");
    reserved_mode_a: assert property (ctl_wr_in && wdata_in[1] && mode == 2'h3 |=> !busy)
        else $error("reserved mode started programming");
    busy_len_a: assert property ($fell(busy) |-> busy_cnt_ff == want)
        else $error("programming time wrong");
    mode_lock_a: assert property (busy && $past(busy) |-> $stable(mode))
        else $error("mode changed while busy");
    addr_lock_a: assert property (busy && addr_wr_in |=> $stable(addr_rd_out))
        else $error("address changed while busy");
    read_refuse_a: assert property (busy && ctl_wr_in && wdata_in[0] |=> $stable(data_rd_out))
        else $error("read accepted while busy");
    trig_stall_a: assert property ($rose(busy) |-> trig_stall_s)
        else $error("trigger stall length wrong");
    read_stall_a: assert property (ctl_wr_in && wdata_in[0] && !wdata_in[1] && !busy |=> read_stall_s)
        else $error("read stall length wrong");
endmodule
bind eepc_ctrl eepc_ctrl_sva #(.ATOMIC_CYCLES(ATOMIC_CYCLES), .SPLIT_CYCLES(SPLIT_CYCLES)) eepc_ctrl_sva_i (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .ctl_wr_in(ctl_wr_in),
    .addr_wr_in(addr_wr_in), .data_wr_in(data_wr_in), .wdata_in(wdata_in),
    .global_irq_en_in(global_irq_en_in), .ctl_rd_out(ctl_rd_out), .addr_rd_out(addr_rd_out),
    .data_rd_out(data_rd_out), .ready_irq_out(ready_irq_out), .cpu_stall_out(cpu_stall_out));
`default_nettype wire

//--- dv/eepc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl_tb;
    import eepc_pkg::*;
    // Short programming times keep the run brief.
    localparam int ATOM = 20;
    localparam int SPLT = 10;
    logic        clk_in, rst_in, por_in, ctl_wr, addr_wr, data_wr, gie, ie, irq, stall;
    logic [7:0]  wdata, ctl_rd, addr_rd, data_rd, a, d;
    logic [7:0]  mem [64];
    logic [31:0] seed;
    logic [1:0]  cur_m;
    int          mismatches, num_checks;
    eepc_ctrl #(.ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLT)) eepc_ctrl_i (.clk_in(clk_in),
        .rst_in(rst_in), .por_in(por_in), .ctl_wr_in(ctl_wr), .addr_wr_in(addr_wr),
        .data_wr_in(data_wr), .wdata_in(wdata), .global_irq_en_in(gie), .ctl_rd_out(ctl_rd),
        .addr_rd_out(addr_rd), .data_rd_out(data_rd), .ready_irq_out(irq), .cpu_stall_out(stall));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] prog_result(input logic [1:0] m, input logic [7:0] old, dd);
        return (m == 2'h0) ? dd : (m == 2'h1) ? 8'hFF : old & dd;
    endfunction
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input int k, input logic [7:0] v);
        @(negedge clk_in);
        wdata = v;
        {ctl_wr, addr_wr, data_wr} = {k == 0, k == 1, k == 2};
        @(negedge clk_in);
        {ctl_wr, addr_wr, data_wr} = 3'h0;
    endtask
    task automatic prog(input logic [1:0] m, input logic [7:0] dd, input int gap, input logic rs);
        int  nb;
        int  ns;
        logic ok;
        ok = (gap <= 2) && (m != 2'h3);
        nb = 0;
        ns = 0;
        wr(1, a);
        wr(2, dd);
        check("data reg", data_rd, dd);
        gie = seed[4];
        wr(0, {2'h0, m, ie, 3'h4});
        repeat (gap) @(negedge clk_in);
        wr(0, {2'h0, m, ie, 3'h6});
        cur_m = m;
        while (ctl_rd[1] === 1'b1 && nb < 400) begin
            ns += int'(stall === 1'b1);
            if (nb == 3) check("irq busy", irq, 20'h0);
            ctl_wr = (nb == 4);
            addr_wr = (nb == 6);
            rst_in = rs && (nb == 8);
            wdata = (nb == 4) ? {2'h0, ~m, ie, 3'h1} : ~a;
            nb++;
            @(negedge clk_in);
        end
        {ctl_wr, addr_wr, rst_in} = 3'h0;
        if (rs) ie = 1'b0;
        if (ok) mem[a[5:0]] = prog_result(m, mem[a[5:0]], dd);
        check("busy cycles", 20'(nb), !ok ? 20'h0 : (m == 2'h0) ? 20'(ATOM) : 20'(SPLT));
        check("trig stall", 20'(ns), ok ? 20'h2 : 20'h0);
        if (ok) begin
            check("mode kept", ctl_rd[5:4], m);
            check("addr kept", addr_rd, rs ? 8'h00 : {2'h0, a[5:0]});
            check("data kept", data_rd, rs ? 8'h00 : dd);
        end
        check("irq idle", irq, ie & gie);
    endtask
    task automatic rd();
        int ns;
        ns = 0;
        wr(1, a);
        check("address", addr_rd, {2'h0, a[5:0]});
        wr(0, {2'h0, cur_m, ie, 3'h1});
        check("read data", data_rd, mem[a[5:0]]);
        while (stall === 1'b1 && ns < 20) begin
            ns++;
            @(negedge clk_in);
        end
        check("read stall", 20'(ns), 20'h4);
        check("strobe bit", ctl_rd[0], 20'h0);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // The whole sequence needs about a thousand cycles, so this only fires on a hang.
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        seed = 32'h1050;
        {ctl_wr, addr_wr, data_wr, gie, ie, por_in, rst_in} = 7'h03;
        wdata = 8'h00;
        cur_m = 2'h0;
        repeat (6) @(negedge clk_in);
        {por_in, rst_in} = 2'h0;
        check("ctl reset", ctl_rd, 8'h00);
        wr(0, 8'h28);
        check("ctl write", ctl_rd, 8'h28);
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        check("ctl idle reset", ctl_rd, 8'h00);
        wr(0, 8'h04);
        repeat (3) @(negedge clk_in);
        check("arm held", ctl_rd[2], 20'h1);
        @(negedge clk_in);
        check("arm cleared", ctl_rd[2], 20'h0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {ie, d, a} = seed[16:0];
            for (int k = 0; k < 5; k++) begin
                seed = lfsr(seed);
                prog((k < 4) ? 2'(k) : 2'h0, d ^ seed[7:0], (k == 0) ? int'(seed[9:8]) % 3 : k - 1,
                     i == 2 && k == 0);
                rd();
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire

//--- hw/eepc_ctrl.sv
// Operation
// - Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode field writes are ignored while the trigger bit shows busy.
// - Reset clears the mode field to 00 unless programming is in progress.
// - Ready interrupt is a level when enabled, global flag set, and idle.
// - Trigger starts programming only within four cycles of master enable.
// - Master enable clears itself four cycles after software sets it.
// - Trigger bit stays set as busy until programming time elapses.
// - A trigger that starts programming stalls the CPU for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - Read strobe stalls the CPU for four cycles, two when the same write starts programming.
// - While busy, read strobes are refused and address writes are ignored.
// - Address register holds a six-bit linear address, locations 0 to 63.
// - Data register supplies write data and receives read data.
// - Programming in progress runs to completion across a reset.
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl
    import eepc_pkg::*;
#(
    parameter int ATOMIC_CYCLES = ATOMIC_TIME_US * CLK_MHZ,
    parameter int SPLIT_CYCLES  = SPLIT_TIME_US * CLK_MHZ
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        por_in,
    input  wire logic                        ctl_wr_in,
    input  wire logic                        addr_wr_in,
    input  wire logic                        data_wr_in,
    input  wire logic [7:0]                  wdata_in,
    input  wire logic                        global_irq_en_in,
    output logic      [7:0]                  ctl_rd_out,
    output logic      [7:0]                  addr_rd_out,
    output logic      [7:0]                  data_rd_out,
    output logic                             ready_irq_out,
    output logic                             cpu_stall_out
);
    import eepc_pkg::*;

    // ------------------------------------------------------------
    // Decoded write fields
    // ------------------------------------------------------------
    logic          wr_read_strobe;
    logic          wr_trigger;
    logic          wr_master_en;
    logic          wr_ready_ie;
    eepc_mode_type wr_mode;

    assign wr_read_strobe = ctl_wr_in & wdata_in[BIT_READ_STROBE];
    assign wr_trigger     = ctl_wr_in & wdata_in[BIT_PROG_TRIG];
    assign wr_master_en   = ctl_wr_in & wdata_in[BIT_MASTER_EN];
    assign wr_ready_ie    = wdata_in[BIT_READY_IE];
    assign wr_mode        = eepc_mode_type'(wdata_in[BIT_MODE_HI:BIT_MODE_LO]);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // The programming engine lives on the power-on reset only, so that the
    // system reset cannot abort a cell mid-program and damage it.
    logic                  busy_ff;
    logic [PROG_CNT_W-1:0] prog_cnt_ff;
    eepc_mode_type         mode_ff;
    eepc_cmd_type          cmd_ff;
    logic                  master_en_ff;
    logic [ARM_CNT_W-1:0]  arm_cnt_ff;
    logic                  ready_ie_ff;
    logic [ADDR_W-1:0]     addr_ff;
    logic [DATA_W-1:0]     data_ff;
    logic [STALL_CNT_W-1:0] stall_cnt_ff;
    logic [DATA_W-1:0]     mem_rd_data;

    logic                  start_prog;
    logic                  do_read;
    logic                  prog_done;
    logic [PROG_CNT_W-1:0] load_cnt;
    logic [PROG_CNT_W-1:0] nxt_prog_cnt;
    logic                  nxt_busy;
    eepc_mode_type         nxt_mode;
    logic [STALL_CNT_W-1:0] nxt_stall_cnt;
    eepc_cmd_type          nxt_cmd;
    eepc_cmd_type          commit;

    // ------------------------------------------------------------
    // Programming start and timing
    // ------------------------------------------------------------
    assign start_prog = wr_trigger & master_en_ff & ~busy_ff
                        & (mode_ff != MODE_RESERVED);
    assign prog_done  = busy_ff & (prog_cnt_ff == PROG_CNT_W'(1));
    assign load_cnt   = (mode_ff == MODE_ATOMIC) ? PROG_CNT_W'(ATOMIC_CYCLES)
                                                 : PROG_CNT_W'(SPLIT_CYCLES);

    assign nxt_busy     = start_prog | (busy_ff & ~prog_done);
    assign nxt_prog_cnt = start_prog ? load_cnt
                        : (busy_ff ? prog_cnt_ff - PROG_CNT_W'(1) : prog_cnt_ff);

    // Mode writes land only while idle; an idle system reset returns it to atomic.
    assign nxt_mode = (rst_in & ~busy_ff) ? MODE_ATOMIC
                    : (ctl_wr_in & ~busy_ff) ? wr_mode : mode_ff;

    // Address and data are captured at the start so the commit is self-contained.
    assign nxt_cmd.valid = start_prog | (cmd_ff.valid & ~prog_done);
    assign nxt_cmd.mode  = start_prog ? mode_ff : cmd_ff.mode;
    assign nxt_cmd.addr  = start_prog ? addr_ff : cmd_ff.addr;
    assign nxt_cmd.data  = start_prog ? data_ff : cmd_ff.data;

    // The cell is written on the edge at which busy falls, so a read issued
    // right after completion already sees the new content.
    assign commit.valid = prog_done & cmd_ff.valid;
    assign commit.mode  = cmd_ff.mode;
    assign commit.addr  = cmd_ff.addr;
    assign commit.data  = cmd_ff.data;

    always_ff @(posedge clk_in or posedge por_in) begin
        if (por_in) begin
            busy_ff     <= 1'b0;
            prog_cnt_ff <= '0;
            mode_ff     <= MODE_ATOMIC;
            cmd_ff      <= '0;
        end else begin
            busy_ff     <= nxt_busy;
            prog_cnt_ff <= nxt_prog_cnt;
            mode_ff     <= nxt_mode;
            cmd_ff      <= nxt_cmd;
        end
    end

    // ------------------------------------------------------------
    // Master enable window
    // ------------------------------------------------------------
    // A new enable write restarts the window; it wins over the automatic clear.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            master_en_ff <= 1'b0;
            arm_cnt_ff   <= '0;
        end else if (wr_master_en) begin
            master_en_ff <= 1'b1;
            arm_cnt_ff   <= ARM_CNT_W'(ARM_WINDOW_CYC);
        end else if (master_en_ff) begin
            master_en_ff <= (arm_cnt_ff != ARM_CNT_W'(1));
            arm_cnt_ff   <= arm_cnt_ff - ARM_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Address, data, interrupt enable
    // ------------------------------------------------------------
    assign do_read = wr_read_strobe & ~busy_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_ie_ff <= 1'b0;
            addr_ff     <= ZERO_ADDR;
            data_ff     <= ZERO_BYTE;
        end else begin
            if (ctl_wr_in) begin
                ready_ie_ff <= wr_ready_ie;
            end
            if (addr_wr_in & ~busy_ff) begin
                addr_ff <= wdata_in[ADDR_W-1:0];
            end
            if (do_read) begin
                data_ff <= mem_rd_data;
            end else if (data_wr_in) begin
                data_ff <= wdata_in;
            end
        end
    end

    // ------------------------------------------------------------
    // CPU stall
    // ------------------------------------------------------------
    assign nxt_stall_cnt = start_prog ? STALL_CNT_W'(PROG_STALL_CYC)
                         : do_read ? STALL_CNT_W'(READ_STALL_CYC)
                         : (stall_cnt_ff != '0) ? stall_cnt_ff - STALL_CNT_W'(1)
                         : stall_cnt_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stall_cnt_ff <= '0;
        end else begin
            stall_cnt_ff <= nxt_stall_cnt;
        end
    end

    assign cpu_stall_out = (stall_cnt_ff != '0);

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    eepc_mem #(
        .DEPTH (MEM_DEPTH)
    ) eepc_mem_i (
        .clk_in      (clk_in),
        .commit_in   (commit),
        .rd_addr_in  (addr_ff),
        .rd_data_out (mem_rd_data)
    );

    // ------------------------------------------------------------
    // Read-back and interrupt
    // ------------------------------------------------------------
    eepc_ctl_type ctl_view;

    // The read strobe completes within its own cycle, so it always reads zero.
    assign ctl_view.reserved         = 2'h0;
    assign ctl_view.program_mode_sel = mode_ff;
    assign ctl_view.ready_irq_en     = ready_ie_ff;
    assign ctl_view.master_prog_en   = master_en_ff;
    assign ctl_view.prog_trigger     = busy_ff;
    assign ctl_view.read_strobe      = 1'b0;

    assign ctl_rd_out  = ctl_view;
    assign addr_rd_out = {2'h0, addr_ff};
    assign data_rd_out = data_ff;

    assign ready_irq_out = ready_ie_ff & global_irq_en_in & ~busy_ff;

endmodule
`default_nettype wire

//--- hw/eepc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_mem
    import eepc_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input  wire logic                 clk_in,
    input  wire eepc_pkg::eepc_cmd_type commit_in,
    input  wire logic [eepc_pkg::ADDR_W-1:0] rd_addr_in,
    output logic      [eepc_pkg::DATA_W-1:0] rd_data_out
);
    import eepc_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // The array has no reset: non-volatile content survives any reset.
    logic [DATA_W-1:0] cells [DEPTH];
    logic [DATA_W-1:0] nxt_cell;
    logic [DATA_W-1:0] old_cell;

    assign old_cell = cells[commit_in.addr];

    // A write-only pass can only clear bits, so an unerased cell is corrupted.
    always_comb begin
        case (commit_in.mode)
            MODE_ATOMIC: nxt_cell = commit_in.data;
            MODE_ERASE:  nxt_cell = ERASED_BYTE;
            MODE_WRITE:  nxt_cell = old_cell & commit_in.data;
            default:     nxt_cell = old_cell;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (commit_in.valid) begin
            cells[commit_in.addr] <= nxt_cell;
        end
    end

    assign rd_data_out = cells[rd_addr_in];

endmodule
`default_nettype wire

//--- hw/eepc_pkg.sv
package eepc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 8;
    localparam int MEM_DEPTH = 64;

    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_PROG_TRIG   = 1;
    localparam int BIT_MASTER_EN   = 2;
    localparam int BIT_READY_IE    = 3;
    localparam int BIT_MODE_LO     = 4;
    localparam int BIT_MODE_HI     = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int ATOMIC_TIME_US   = 3400;
    localparam int SPLIT_TIME_US    = 1800;
    localparam int ARM_WINDOW_CYC   = 4;
    localparam int PROG_STALL_CYC   = 2;
    localparam int READ_STALL_CYC   = 4;
    localparam int PROG_CNT_W       = 20;
    localparam int STALL_CNT_W      = 3;
    localparam int ARM_CNT_W        = 3;

    // ------------------------------------------------------------
    // Reset and fill values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;
    localparam logic [ADDR_W-1:0] ZERO_ADDR   = 6'h00;

    typedef enum logic [1:0] {
        MODE_ATOMIC   = 2'h0,
        MODE_ERASE    = 2'h1,
        MODE_WRITE    = 2'h2,
        MODE_RESERVED = 2'h3
    } eepc_mode_type;

    typedef struct packed {
        logic [1:0]    reserved;
        eepc_mode_type program_mode_sel;
        logic          ready_irq_en;
        logic          master_prog_en;
        logic          prog_trigger;
        logic          read_strobe;
    } eepc_ctl_type;

    typedef struct packed {
        logic                valid;
        eepc_mode_type       mode;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } eepc_cmd_type;

endpackage
